/* common/pep_pkg.sv */
// constants, field layouts and state type of the peripheral interrupt enable/priority bank
package pep_pkg;

	// register indices; byte address is four times the index
	localparam int IDX_W = 12;
	localparam logic [11:0] IDX_PRIO0 = 12'he1f;
	localparam logic [11:0] IDX_PRIO1 = 12'he20;
	localparam logic [11:0] IDX_PRIO2 = 12'he21;
	localparam logic [11:0] IDX_SERIAL = 12'he2d;
	localparam logic [11:0] IDX_TMATCH = 12'he2e;
	localparam logic [11:0] IDX_TGATE = 12'he2f;
	localparam logic [11:0] IDX_CAPCOMP = 12'he30;
	localparam logic [11:0] IDX_SYSTEM = 12'he31;
	localparam logic [11:0] IDX_MEASURE = 12'he32;
	localparam logic [11:0] IDX_STATUS = 12'he40;
	localparam logic [11:0] IDX_MASK = 12'he41;

	// enable groups, position in the enable array
	localparam int GRP_SERIAL = 0;
	localparam int GRP_TMATCH = 1;
	localparam int GRP_TGATE = 2;
	localparam int GRP_CAPCOMP = 3;
	localparam int GRP_SYSTEM = 4;
	localparam int GRP_MEASURE = 5;
	localparam int N_EN = 6;
	localparam int N_PRIO = 3;

	// per enable group: index, implemented bits, value after reset
	localparam logic [5:0][11:0] EN_IDX = {IDX_MEASURE, IDX_SYSTEM, IDX_CAPCOMP,
		IDX_TGATE, IDX_TMATCH, IDX_SERIAL};
	localparam logic [5:0][7:0] EN_MASK = {8'h3f, 8'he1, 8'h1f, 8'h0f, 8'hff, 8'h3f};
	localparam logic [5:0][7:0] EN_RST = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// per priority register: index, implemented bits, value after reset
	localparam logic [2:0][11:0] PRIO_IDX = {IDX_PRIO2, IDX_PRIO1, IDX_PRIO0};
	localparam logic [2:0][7:0] PRIO_MASK = {8'hc7, 8'hc3, 8'h3f};
	localparam logic [2:0][7:0] PRIO_RST = {8'hc1, 8'hc3, 8'h3f};

	// event status bits
	localparam int ST_W = 3;
	localparam int ST_HI_RISE = 0;
	localparam int ST_LO_RISE = 1;
	localparam int ST_BLOCKED = 2;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;

	// bus codes
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// whole state of the bank
	typedef struct packed {
		logic [5:0][7:0] en;        // enable registers
		logic [2:0][7:0] prio;      // priority registers
		logic [5:0][7:0] prev_flag; // flags one cycle ago
		logic wr_pend;              // write data phase pending
		logic [11:0] wr_idx;        // index of pending write
		logic [2:0] status;         // sticky event bits
		logic [2:0] mask;           // event mask
		logic req_hi;               // high level request
		logic req_lo;               // low level request
		logic [31:0] rdata;         // read data
	} pep_state_t;

	localparam pep_state_t STATE_RST = '{en: EN_RST, prio: PRIO_RST, prev_flag: '0,
		wr_pend: 1'b0, wr_idx: 12'h000, status: STATUS_RST, mask: MASK_RST,
		req_hi: 1'b0, req_lo: 1'b0, rdata: 32'h0000_0000};

endpackage

/* dv/pep_bank_tb.sv */
// self-checking bench of the enable and priority bank
`timescale 1ns/100ps
module pep_bank_tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_hi_req, irq_lo_req, irq;
	logic [31:0] haddr, hwdata, hrdata, seed, rd, rw; // rw: random scratch word
	logic [63:0] r64; // random scratch
	logic [1:0] htrans;
	logic [2:0] hsize, sz; // sz: size that the bus task puts on hsize
	logic [5:0][7:0] periph_flag, en_src_prio, ev, clr;
	logic [2:0][7:0] prio_src_req;
	logic [8:0][11:0] ridx; // 0..5 enable groups, 6..8 priority registers
	logic [8:0][7:0] rmask, rrst, shadow; // implemented bits, reset, expected
	int num_errors, checks_done, k;
	//////////////////////////////////////////////////////////////////////
	pep_bank pep_bank_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.periph_flag(periph_flag), .en_src_prio(en_src_prio),
		.prio_src_req(prio_src_req), .irq_hi_req(irq_hi_req), .irq_lo_req(irq_lo_req),
		.irq(irq));
	pep_src_model pep_src_model_inst (.hclk(hclk), .hresetn(hresetn), .ev(ev), .clr(clr),
		.periph_flag(periph_flag));
	//////////////////////////////////////////////////////////////////////
	// xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected {hi, lo} request lines from the shadow registers
	function automatic logic [31:0] exp_req();
		logic h, l;
		h = 1'b0;
		l = 1'b0;
		for (int i = 0; i < 6; i++) begin
			h |= |(periph_flag[i] & shadow[i] & en_src_prio[i]);
			l |= |(periph_flag[i] & shadow[i] & ~en_src_prio[i]);
		end
		for (int i = 0; i < 3; i++) begin
			h |= |(prio_src_req[i] & shadow[6+i]);
			l |= |(prio_src_req[i] & ~shadow[6+i] & rmask[6+i]);
		end
		return {30'h0, h, l};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// wait for ready under a bound; ready and read data are taken as they stand
	// before the edge that ends the phase, so no race with the registers
	task automatic wait_ready(output logic [31:0] data);
		int n;
		logic rdy;
		n = 0;
		rdy = 1'b0;
		data = 32'h0000_0000;
		while (!rdy && n < 50) begin
			@(negedge hclk);
			rdy = (hreadyout === 1'b1);
			data = hrdata;
			n++;
			@(posedge hclk);
		end
		if (!rdy) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	// one single transfer of size sz; read data lands in rd
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		logic [31:0] addr_phase_data;
		hsel <= 1'b1;
		haddr <= {18'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= sz;
		wait_ready(addr_phase_data);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(rd);
	endtask
	task automatic wr_reg(input int r, input logic [31:0] d);
		bus(1'b1, ridx[r], d);
		shadow[r] = d[7:0] & rmask[r];
	endtask
	// compare request lines after they settle
	task automatic settle_req();
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		check({30'h0, irq_hi_req, irq_lo_req}, exp_req());
		@(posedge hclk);
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
		{en_src_prio, ev, clr, prio_src_req} = '0;
		seed = 32'h0000_005a;
		sz = pep_pkg::HSIZE_WORD;
		num_errors = 0;
		checks_done = 0;
		ridx = {pep_pkg::IDX_PRIO2, pep_pkg::IDX_PRIO1, pep_pkg::IDX_PRIO0,
			pep_pkg::IDX_MEASURE, pep_pkg::IDX_SYSTEM, pep_pkg::IDX_CAPCOMP,
			pep_pkg::IDX_TGATE, pep_pkg::IDX_TMATCH, pep_pkg::IDX_SERIAL};
		rmask = {8'hc7, 8'hc3, 8'h3f, 8'h3f, 8'he1, 8'h1f, 8'h0f, 8'hff, 8'h3f};
		rrst = {8'hc1, 8'hc3, 8'h3f, 48'h0000_0000_0000};
		shadow = rrst;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values of every enable and priority register
		for (k = 0; k < 9; k++) begin
			bus(1'b0, ridx[k], 32'h0);
			check(rd, {24'h0, rrst[k]});
		end
		$display("test reset values done");
		// flags with every enable off: no request, blocked event seen
		ev <= '1;
		@(posedge hclk);
		ev <= '0;
		settle_req();
		bus(1'b0, pep_pkg::IDX_STATUS, 32'h0);
		check(rd, 32'h4);
		bus(1'b1, pep_pkg::IDX_MASK, 32'h7);
		@(negedge hclk);
		check({31'h0, irq}, 32'h1);
		@(posedge hclk);
		bus(1'b1, pep_pkg::IDX_STATUS, 32'h7);
		@(negedge hclk);
		check({31'h0, irq}, 32'h0);
		@(posedge hclk);
		// timer 1 match enabled, high priority
		clr <= '1;
		@(posedge hclk);
		clr <= '0;
		en_src_prio <= '1;
		wr_reg(1, 32'h1);
		ev[1] <= 8'h01;
		@(posedge hclk);
		ev <= '0;
		settle_req();
		@(negedge hclk);
		check({30'h0, irq_hi_req, irq_lo_req}, 32'h2);
		@(posedge hclk);
		bus(1'b0, pep_pkg::IDX_STATUS, 32'h0);
		check(rd, 32'h1);
		bus(1'b1, pep_pkg::IDX_STATUS, 32'h1);
		@(negedge hclk);
		check({31'h0, irq}, 32'h0);
		@(posedge hclk);
		$display("test event interrupt done");
		// all ones written, implemented bits read back
		for (k = 0; k < 9; k++) begin
			wr_reg(k, 32'hffff_ffff);
			bus(1'b0, ridx[k], 32'h0);
			check(rd, {24'h0, shadow[k]});
		end
		// unmapped place takes no write and reads zero
		bus(1'b1, 12'h100, 32'hff);
		bus(1'b0, 12'h100, 32'h0);
		check(rd, 32'h0);
		// a byte-size write is ignored, the register keeps its value
		sz = 3'h0;
		bus(1'b1, pep_pkg::IDX_TMATCH, 32'h0);
		sz = pep_pkg::HSIZE_WORD;
		bus(1'b0, pep_pkg::IDX_TMATCH, 32'h0);
		check(rd, {24'h0, shadow[1]});
		$display("test layout done");
		// random enables, priorities, flags and clears
		for (int t = 0; t < 40; t++) begin
			k = int'(rnd() % 9);
			wr_reg(k, rnd());
			r64 = {rnd(), rnd()};
			rw = rnd() & rnd();
			ev <= r64[47:0] & {rw[15:0], rw};
			rw = rnd();
			clr <= {r64[15:0], r64[63:32]} & {rw[15:0], rw};
			r64 = {rnd(), rnd()};
			en_src_prio <= r64[47:0];
			rw = rnd() & rnd();
			prio_src_req <= rw[23:0];
			@(posedge hclk);
			ev <= '0;
			clr <= '0;
			settle_req();
		end
		$display("test random routing done");
		// reset again in mid-run: every enable and priority register back at its reset value
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		shadow = rrst;
		for (k = 0; k < 9; k++) begin
			bus(1'b0, ridx[k], 32'h0);
			check(rd, {24'h0, rrst[k]});
		end
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule // pep_bank_tb

/* dv/pep_src_model.sv */
// peripheral flag sources that feed the bank
`timescale 1ns/100ps
module pep_src_model (
	input wire logic hclk, // system clock
	input wire logic hresetn, // reset, active low
	input wire logic [5:0][7:0] ev, // one-cycle event pulses
	input wire logic [5:0][7:0] clr, // software clears of flags
	output logic [5:0][7:0] periph_flag // latched flags
);
	//////////////////////////////////////////////////////////////////////
	// a flag is set by its event and held until software clears it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			periph_flag <= '0;
		end else begin
			periph_flag <= (periph_flag & ~clr) | ev;
		end
	end
endmodule // pep_src_model

/* src/pep_bank.sv */
// peripheral interrupt enable and priority bank with an ahb-lite register slave
`timescale 1ns/100ps

// Contract
// - enable one lets its source request
// - priority one routes high, zero routes low
// - all implemented enable bits clear on reset
// - listed priority bits set on reset
// - third priority register layout and reset mix
// - timer match enables bits 0..7, timers 1..8
// - timer gate enables at bits 0..3
// - capture/compare enables bits 0..4 only
// - scanner, checksum, nonvolatile, waveform enable layout
// - measurement timer enables at bits 5..0
// - serial receive/transmit enables, receive odd bit
// - first priority register layout
// - second priority register layout
// - peripheral flags latched, enables gate them
module pep_bank (
	input wire logic hclk, // system clock, 20 MHz
	input wire logic hresetn, // asynchronous reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // slave response
	output logic [31:0] hrdata, // read data
	input wire logic [5:0][7:0] periph_flag, // latched flags, one byte per enable group
	input wire logic [5:0][7:0] en_src_prio, // priorities of enable-group sources
	input wire logic [2:0][7:0] prio_src_req, // enabled requests of priority sources
	output logic irq_hi_req, // high priority request to the core
	output logic irq_lo_req, // low priority request to the core
	output logic irq // event interrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// state and helper nets

	pep_pkg::pep_state_t s; // current state
	pep_pkg::pep_state_t next_s; // next state
	logic [5:0][7:0] en_pend; // flags passed by their enable
	logic [5:0][7:0] en_blk_rise; // new flags held back by a cleared enable
	logic [2:0][7:0] pr_hi; // priority sources routed high
	logic [2:0][7:0] pr_lo; // priority sources routed low
	logic hi_any; // something asks for the high level
	logic lo_any; // something asks for the low level
	logic xfer; // address phase taken this edge
	logic addr_ok; // address inside the decoded window
	logic [11:0] a_idx; // word index of the address phase

	////////////////////////////////////////////////////////////////////////////////
	// gating of flags and priority routing

	// per enable group gating
	genvar g;
	generate
		for (g = 0; g < pep_pkg::N_EN; g++) begin : g_en
			// only implemented bits pass
			assign en_pend[g] = periph_flag[g] & s.en[g] & pep_pkg::EN_MASK[g];
			// a flag that rises while its enable is clear
			assign en_blk_rise[g] = periph_flag[g] & ~s.prev_flag[g] & ~s.en[g]
				& pep_pkg::EN_MASK[g];
		end
		for (g = 0; g < pep_pkg::N_PRIO; g++) begin : g_pr
			// route by the priority bit
			assign pr_hi[g] = prio_src_req[g] & s.prio[g] & pep_pkg::PRIO_MASK[g];
			assign pr_lo[g] = prio_src_req[g] & ~s.prio[g] & pep_pkg::PRIO_MASK[g];
		end
	endgenerate

	// level selection per source
	assign hi_any = (|(en_pend & en_src_prio)) | (|pr_hi);
	assign lo_any = (|(en_pend & ~en_src_prio)) | (|pr_lo);

	// address decode
	assign xfer = hsel & hready & htrans[1];
	assign a_idx = haddr[13:2];
	assign addr_ok = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'b00);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	// one pass: write data phase, events, then address phase and read data
	always_comb begin
		next_s = s;
		next_s.prev_flag = periph_flag;
		// requests follow the gated sources one cycle later
		next_s.req_hi = hi_any;
		next_s.req_lo = lo_any;
		// write data phase: hwdata stands now
		if (s.wr_pend) begin
			for (int i = 0; i < pep_pkg::N_EN; i++) begin
				// unimplemented bits stay zero
				if (s.wr_idx == pep_pkg::EN_IDX[i]) begin
					next_s.en[i] = hwdata[7:0] & pep_pkg::EN_MASK[i];
				end
			end
			for (int i = 0; i < pep_pkg::N_PRIO; i++) begin
				if (s.wr_idx == pep_pkg::PRIO_IDX[i]) begin
					next_s.prio[i] = hwdata[7:0] & pep_pkg::PRIO_MASK[i];
				end
			end
			// write one to clear
			if (s.wr_idx == pep_pkg::IDX_STATUS) begin
				next_s.status = s.status & ~hwdata[2:0];
			end
			if (s.wr_idx == pep_pkg::IDX_MASK) begin
				next_s.mask = hwdata[2:0];
			end
		end
		// events set after the clear, so a set wins
		next_s.status[pep_pkg::ST_HI_RISE] = next_s.status[pep_pkg::ST_HI_RISE]
			| (hi_any & ~s.req_hi);
		next_s.status[pep_pkg::ST_LO_RISE] = next_s.status[pep_pkg::ST_LO_RISE]
			| (lo_any & ~s.req_lo);
		next_s.status[pep_pkg::ST_BLOCKED] = next_s.status[pep_pkg::ST_BLOCKED]
			| (|en_blk_rise);
		// address phase: only whole-word writes are stored
		next_s.wr_pend = xfer & hwrite & addr_ok & (hsize == pep_pkg::HSIZE_WORD);
		next_s.wr_idx = a_idx;
		// read data from the updated values, so a read right after a write sees it
		next_s.rdata = 32'h0000_0000;
		if (xfer && !hwrite && addr_ok) begin
			for (int i = 0; i < pep_pkg::N_EN; i++) begin
				if (a_idx == pep_pkg::EN_IDX[i]) begin
					next_s.rdata[7:0] = next_s.en[i];
				end
			end
			for (int i = 0; i < pep_pkg::N_PRIO; i++) begin
				if (a_idx == pep_pkg::PRIO_IDX[i]) begin
					next_s.rdata[7:0] = next_s.prio[i];
				end
			end
			if (a_idx == pep_pkg::IDX_STATUS) begin
				next_s.rdata[2:0] = next_s.status;
			end
			if (a_idx == pep_pkg::IDX_MASK) begin
				next_s.rdata[2:0] = next_s.mask;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// reset loads enables cleared and priorities at their defaults
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= pep_pkg::STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign irq_hi_req = s.req_hi;
	assign irq_lo_req = s.req_lo;
	// level interrupt while any unmasked event is pending
	assign irq = |(s.status & s.mask);

	////////////////////////////////////////////////////////////////////////////////
	// checks

	// an enabled low-priority flag raises the low line next cycle
	property p_en_pass;
		@(posedge hclk) disable iff (!hresetn)
		(|(periph_flag & s.en & ~en_src_prio)) |=> irq_lo_req;
	endproperty
	a_en_pass: assert property (p_en_pass) else $error("enabled flag gave no request");

	// with nothing enabled and nothing routed, both lines drop
	property p_quiet;
		@(posedge hclk) disable iff (!hresetn)
		((periph_flag & s.en) == '0) && (prio_src_req == '0) |=> !irq_hi_req && !irq_lo_req;
	endproperty
	a_quiet: assert property (p_quiet) else $error("request without enabled source");

	// a high priority source drives the high line
	property p_prio_hi;
		@(posedge hclk) disable iff (!hresetn)
		(|(prio_src_req & s.prio & pep_pkg::PRIO_MASK)) |=> irq_hi_req;
	endproperty
	a_prio_hi: assert property (p_prio_hi) else $error("high source not on high line");

	// a low priority source alone keeps the high line down
	property p_prio_lo;
		@(posedge hclk) disable iff (!hresetn)
		((prio_src_req & s.prio) == '0) && (en_pend == '0) && (|(prio_src_req
			& pep_pkg::PRIO_MASK)) |=> irq_lo_req && !irq_hi_req;
	endproperty
	a_prio_lo: assert property (p_prio_lo) else $error("low source misrouted");

	// after reset release enables are clear
	property p_rst_en;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (s.en == '0);
	endproperty
	a_rst_en: assert property (p_rst_en) else $error("enables not cleared by reset");

	// after reset release the first two priority registers hold their defaults
	property p_rst_prio;
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (s.prio[0] == 8'h3f) && (s.prio[1] == 8'hc3);
	endproperty
	a_rst_prio: assert property (p_rst_prio) else $error("priority reset wrong");

	// third priority register: reset value and unused bits
	property p_prio2;
		@(posedge hclk) disable iff (!hresetn)
		($rose(hresetn) |-> s.prio[2] == 8'hc1) and (s.prio[2][5:3] == 3'h0);
	endproperty
	a_prio2: assert property (p_prio2) else $error("third priority register wrong");

	// a timer match write is stored whole
	property p_match_store;
		@(posedge hclk) disable iff (!hresetn)
		s.wr_pend && (s.wr_idx == pep_pkg::IDX_TMATCH)
			|=> s.en[pep_pkg::GRP_TMATCH] == $past(hwdata[7:0]);
	endproperty
	a_match_store: assert property (p_match_store) else $error("match write lost");

	// unimplemented enable bits never set
	property p_unused_en;
		@(posedge hclk) disable iff (!hresetn)
		(s.en[pep_pkg::GRP_TGATE][7:4] == 4'h0) && (s.en[pep_pkg::GRP_CAPCOMP][7:5] == 3'h0)
			&& (s.en[pep_pkg::GRP_SYSTEM][4:1] == 4'h0)
			&& (s.en[pep_pkg::GRP_MEASURE][7:6] == 2'h0)
			&& (s.en[pep_pkg::GRP_SERIAL][7:6] == 2'h0);
	endproperty
	a_unused_en: assert property (p_unused_en) else $error("unused enable bit set");

	// unimplemented bits of the first two priority registers never set
	property p_unused_prio;
		@(posedge hclk) disable iff (!hresetn)
		(s.prio[0][7:6] == 2'h0) && (s.prio[1][5:2] == 4'h0);
	endproperty
	a_unused_prio: assert property (p_unused_prio) else $error("unused priority bit set");

	// a held flag keeps its request while the enable stays
	property p_flag_hold;
		@(posedge hclk) disable iff (!hresetn)
		(|en_pend) ##1 (en_pend == $past(en_pend)) |-> (irq_hi_req || irq_lo_req);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("held flag lost request");

	// a rising request survives a clear in the same cycle
	property p_set_wins;
		@(posedge hclk) disable iff (!hresetn)
		hi_any && !s.req_hi |=> s.status[pep_pkg::ST_HI_RISE];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

	// main scenarios
	c_hi: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq_hi_req));
	c_lo: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq_lo_req));
	c_blocked: cover property (@(posedge hclk) disable iff (!hresetn)
		s.status[pep_pkg::ST_BLOCKED] && irq);
	c_clash: cover property (@(posedge hclk) disable iff (!hresetn)
		s.wr_pend && (s.wr_idx == pep_pkg::IDX_STATUS) && hi_any && !s.req_hi);

endmodule // pep_bank
